// ===== rtl/adr_pkg.sv
// Purpose: Shared constants for the asynchronous DRAM refresh controller
// Assumes: 100 MHz bus clock, module-relative register offsets
// Notes:   Field positions and reset values are named once here
package adr_pkg;
  // ----------------------------------------------------------------
  // Register offsets (byte, relative to module base)
  // ----------------------------------------------------------------
  localparam logic [8:0] OFS_DRAM_CONFIG = 9'h100; // Control register
  localparam logic [8:0] OFS_BLK0_ADDR_CTRL = 9'h108; // Block 0 address/control
  localparam logic [8:0] OFS_BLK0_MASK = 9'h10C; // Block 0 mask
  localparam logic [8:0] OFS_BLK1_ADDR_CTRL = 9'h110; // Block 1 address/control
  localparam logic [8:0] OFS_BLK1_MASK = 9'h114; // Block 1 mask
  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CFG_SYNC_BIT = 15; // Synchronous select, sticky
  localparam int CFG_RSVD_BIT = 14; // Reserved, reads zero
  localparam int CFG_NO_MUX_BIT = 13; // No address multiplexing
  localparam int CFG_RSW_LSB = 11; // Refresh strobe width field
  localparam int CFG_RPC_LSB = 9; // Refresh precharge field
  localparam int CFG_RCNT_LSB = 0; // Refresh count field
  localparam int CFG_RCNT_W = 9; // Refresh count width
  localparam logic [15:0] CFG_RESET = 16'h0000; // Control reset value
  // ----------------------------------------------------------------
  // Block address/control fields
  // ----------------------------------------------------------------
  localparam int BLK_KEEPALIVE_BIT = 15; // Block refresh enable
  localparam int BLK_BASE_LSB = 18; // Base address field
  localparam int BLK_CAS_LSB = 12; // Column strobe time field
  localparam int BLK_RP_LSB = 10; // Access precharge field
  localparam int BLK_RCD_BIT = 8; // Row to column delay
  localparam logic [31:0] BLK_RESET = 32'h00000000; // Refresh enable clear
  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam logic [2:0] RSW_BASE_CLKS = 3'h2; // Code 0 gives 2 clocks
  localparam logic [2:0] RPC_BASE_CLKS = 3'h1; // Code 0 gives 1 clock
  localparam int RCNT_SCALE_SHIFT = 4; // Interval unit of 16 clocks
  localparam int CNT_W = 13; // Holds up to 8191
endpackage

// ===== rtl/adr_refresh_timer.sv
// Purpose: Periodic refresh request generator
// Assumes: Count field sampled live; new value applies at next reload
// Notes:   Request is a level held until acknowledged or until enable_in drops
module adr_refresh_timer (
  input wire logic clk_sys_in, // Bus clock
  input wire logic sys_rst_in, // Async reset, active high
  input wire logic [8:0] count_field_in, // Refresh count field
  input wire logic enable_in, // Async mode and any block keepalive enabled
  input wire logic ack_in, // Refresh taken
  output logic req_out // Refresh pending
);
  // ----------------------------------------------------------------
  // Interval counter
  // ----------------------------------------------------------------
  logic [12:0] cnt; // Clocks left in interval
  logic [12:0] next_cnt;
  logic next_req;
  logic [12:0] reload; // (field+1)*16 - 1
  logic [4:0] gap; // Clocks since last interval end, saturating
  logic [4:0] next_gap;
  always_comb begin
    // Interval is (field+1)*16 clocks
    reload = 13'({4'h0, count_field_in} << adr_pkg::RCNT_SCALE_SHIFT)
      + 13'h000F;
    next_cnt = cnt;
    next_req = req_out;
    // Helper for the spacing check; a long repetition would be costly
    next_gap = (gap == 5'h1F) ? gap : gap + 5'h01;
    if (!enable_in) begin
      next_cnt = reload;
      next_req = 1'b0;
    end else if (cnt == 13'h0000) begin
      next_cnt = reload;
      next_gap = 5'h00;
      next_req = 1'b1; // Set wins over ack
    end else begin
      next_cnt = cnt - 13'h0001;
      if (ack_in) begin
        next_req = 1'b0;
      end
    end
  end
  // Register the counter state
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt <= 13'h000F;
      req_out <= 1'b0;
      gap <= 5'h1F;
    end else begin
      cnt <= next_cnt;
      req_out <= next_req;
      gap <= next_gap;
    end
  end
  // Request spacing check: interval ends at least 16 clocks apart
  refresh_period_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (enable_in && cnt == 13'h0000) |-> (gap >= 5'h0F))
    else $error("refresh request too early");
endmodule

// ===== rtl/adr_strobe_neg.sv
// Purpose: Falling-edge retiming of DRAM strobes
// Assumes: Inputs come from rising-edge logic of the same clock
// Notes:   Gives half a clock of setup to the DRAM pins
module adr_strobe_neg (
  input wire logic clk_sys_in, // Bus clock
  input wire logic sys_rst_in, // Async reset, active high
  input wire logic [1:0] ras_n_in, // Row strobes, rising timed
  input wire logic [3:0] cas_n_in, // Column strobes, rising timed
  output logic [1:0] ras_n_out, // Row strobes to pins
  output logic [3:0] cas_n_out // Column strobes to pins
);
  // ----------------------------------------------------------------
  // Negedge register
  // ----------------------------------------------------------------
  // Strobes move only on the falling edge
  always_ff @(negedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ras_n_out <= 2'h3;
      cas_n_out <= 4'hF;
    end else begin
      ras_n_out <= ras_n_in;
      cas_n_out <= cas_n_in;
    end
  end
endmodule

// ===== rtl/adr_ctrl.sv
// Purpose: Asynchronous DRAM controller core with register map and refresh
// Assumes: Register port is the internal bus, one access per cycle
// Notes:   Synchronous-mode sequencing is out of scope; only the mode bit is held
module adr_ctrl (
  input wire logic clk_sys_in, // Bus clock
  input wire logic sys_rst_in, // Async reset, active high
  input wire logic reg_sel_in, // Register access strobe
  input wire logic reg_wr_in, // 1 write, 0 read
  input wire logic reg_ext_in, // Access from off-chip master
  input wire logic [8:0] reg_addr_in, // Module-relative byte offset
  input wire logic [31:0] reg_wdata_in, // Write data
  output logic [31:0] reg_rdata_out, // Read data
  output logic reg_ack_out, // Register access done
  input wire logic mem_req_in, // DRAM access request
  input wire logic mem_wr_in, // DRAM access is a write
  input wire logic [31:0] mem_addr_in, // DRAM byte address
  input wire logic [3:0] mem_be_in, // Byte enables, bit3 = MSB lane
  output logic mem_ack_out, // DRAM access termination
  output logic [31:0] dram_addr_out, // Address bus to DRAM
  output logic [1:0] ras_n_out, // Row strobes, active low
  output logic [3:0] cas_n_out, // Column strobes, active low
  output logic write_indicator_n_out, // DRAM write, active low
  output logic sync_mode_out, // Synchronous mode selected
  output logic refresh_busy_out // Refresh in progress
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] dram_config; // Shared control
  logic [31:0] blk_addr_ctrl [2]; // Per-block address/control
  logic [31:0] blk_mask [2]; // Per-block mask
  logic [15:0] next_config;
  logic [31:0] next_addr_ctrl [2];
  logic [31:0] next_mask [2];
  logic [31:0] next_rdata;
  logic next_rack;
  logic wr_en; // Write strobe
  // Off-chip masters may touch only this map, so every decode here is open
  // to them; other resources are refused elsewhere in the chip
  assign wr_en = reg_sel_in & reg_wr_in;
  // Next register values and read mux
  always_comb begin
    next_config = dram_config;
    next_addr_ctrl = blk_addr_ctrl;
    next_mask = blk_mask;
    next_rdata = 32'h00000000;
    next_rack = reg_sel_in;
    if (wr_en) begin
      case (reg_addr_in)
        adr_pkg::OFS_DRAM_CONFIG: begin
          next_config = reg_wdata_in[31:16];
          next_config[adr_pkg::CFG_RSVD_BIT] = 1'b0;
          // Sync bit can only be set
          next_config[adr_pkg::CFG_SYNC_BIT] = dram_config[adr_pkg::CFG_SYNC_BIT]
            | reg_wdata_in[16 + adr_pkg::CFG_SYNC_BIT];
        end
        adr_pkg::OFS_BLK0_ADDR_CTRL: next_addr_ctrl[0] = reg_wdata_in;
        adr_pkg::OFS_BLK0_MASK: next_mask[0] = reg_wdata_in;
        adr_pkg::OFS_BLK1_ADDR_CTRL: next_addr_ctrl[1] = reg_wdata_in;
        adr_pkg::OFS_BLK1_MASK: next_mask[1] = reg_wdata_in;
        default: ; // Unmapped write ignored
      endcase
    end else if (reg_sel_in) begin
      case (reg_addr_in)
        adr_pkg::OFS_DRAM_CONFIG: next_rdata = {dram_config, 16'h0000};
        adr_pkg::OFS_BLK0_ADDR_CTRL: next_rdata = blk_addr_ctrl[0];
        adr_pkg::OFS_BLK0_MASK: next_rdata = blk_mask[0];
        adr_pkg::OFS_BLK1_ADDR_CTRL: next_rdata = blk_addr_ctrl[1];
        adr_pkg::OFS_BLK1_MASK: next_rdata = blk_mask[1];
        default: next_rdata = 32'h00000000; // Unmapped reads zero
      endcase
    end
  end
  // Register file storage
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      dram_config <= adr_pkg::CFG_RESET;
      blk_addr_ctrl[0] <= adr_pkg::BLK_RESET;
      blk_addr_ctrl[1] <= adr_pkg::BLK_RESET;
      blk_mask[0] <= adr_pkg::BLK_RESET;
      blk_mask[1] <= adr_pkg::BLK_RESET;
      reg_rdata_out <= 32'h00000000;
      reg_ack_out <= 1'b0;
    end else begin
      dram_config <= next_config;
      blk_addr_ctrl <= next_addr_ctrl;
      blk_mask <= next_mask;
      reg_rdata_out <= next_rdata;
      reg_ack_out <= next_rack;
    end
  end
  // ----------------------------------------------------------------
  // Decode and refresh request
  // ----------------------------------------------------------------
  logic [1:0] hit; // Block address match
  logic [1:0] keep; // Block refresh enables
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_blk
      // Overlap is software's duty; on a double hit block 1 wins
      assign hit[gi] = ((mem_addr_in[31:18] ^ blk_addr_ctrl[gi][31:18])
        & ~blk_mask[gi][31:18]) == 14'h0000;
      assign keep[gi] = blk_addr_ctrl[gi][adr_pkg::BLK_KEEPALIVE_BIT];
    end
  endgenerate
  logic rf_req; // Refresh pending
  logic rf_ack; // Refresh started
  logic async_mode;
  assign async_mode = ~dram_config[adr_pkg::CFG_SYNC_BIT];
  adr_refresh_timer u_timer (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .count_field_in(dram_config[8:0]),
    .enable_in(async_mode & (|keep)),
    .ack_in(rf_ack),
    .req_out(rf_req)
  );
  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001, // Waiting
    ST_ROW = 6'b000010, // Row strobe, row to column delay
    ST_COL = 6'b000100, // Column strobe held
    ST_PRE = 6'b001000, // Access precharge
    ST_RF = 6'b010000, // Refresh row strobe
    ST_RFPRE = 6'b100000 // Refresh precharge
  } adr_state_e;
  adr_state_e st, next_st;
  logic [2:0] tmr, next_tmr; // Phase clocks left
  logic [0:0] blk, next_blk; // Active block
  logic [1:0] ras_q, next_ras; // Row strobes before retiming
  logic [3:0] cas_q, next_cas;
  logic next_mack, next_wi_n, next_busy, next_rf_ack;
  logic [31:0] next_addr;
  logic [31:0] cur_ctl; // Selected block control
  assign cur_ctl = blk_addr_ctrl[blk];
  assign rf_ack = next_rf_ack;
  // State transitions and strobe values
  always_comb begin
    next_st = st;
    next_tmr = tmr;
    next_blk = blk;
    next_ras = ras_q;
    next_cas = cas_q;
    next_mack = 1'b0;
    next_wi_n = write_indicator_n_out;
    next_busy = refresh_busy_out;
    next_addr = dram_addr_out;
    next_rf_ack = 1'b0;
    case (st)
      ST_IDLE: begin
        // Refresh precedes any new access
        if (rf_req) begin
          next_st = ST_RF;
          next_rf_ack = 1'b1;
          next_busy = 1'b1;
          next_ras = ~keep; // Both enabled blocks together
          // Width code 00..11 gives 2..5 clocks
          next_tmr = adr_pkg::RSW_BASE_CLKS
            + {1'b0, dram_config[adr_pkg::CFG_RSW_LSB +: 2]} - 3'h1;
        end else if (mem_req_in && async_mode && (|hit)) begin
          next_st = ST_ROW;
          next_blk = hit[1] ? 1'b1 : 1'b0;
          next_ras = hit[1] ? 2'b01 : 2'b10; // One strobe per block
          next_wi_n = ~mem_wr_in;
          next_addr = mem_addr_in; // Row address
          next_tmr = {2'h0, blk_addr_ctrl[hit[1]][adr_pkg::BLK_RCD_BIT]};
        end
      end
      ST_ROW: begin
        if (tmr == 3'h0) begin
          next_st = ST_COL;
          // Lane 0 drives MSB byte
          next_cas = ~{mem_be_in[0], mem_be_in[1], mem_be_in[2], mem_be_in[3]};
          // Column address muxed unless disabled
          if (!dram_config[adr_pkg::CFG_NO_MUX_BIT]) begin
            next_addr = {16'h0000, mem_addr_in[31:16]};
          end
          // Access timing from own block
          next_tmr = {1'b0, cur_ctl[adr_pkg::BLK_CAS_LSB +: 2]};
        end else begin
          next_tmr = tmr - 3'h1;
        end
      end
      ST_COL: begin
        if (tmr == 3'h0) begin
          next_st = ST_PRE;
          next_ras = 2'b11;
          next_cas = 4'hF;
          next_mack = 1'b1; // Own termination
          next_wi_n = 1'b1;
          next_tmr = {1'b0, cur_ctl[adr_pkg::BLK_RP_LSB +: 2]};
        end else begin
          next_tmr = tmr - 3'h1;
        end
      end
      ST_PRE: begin
        if (tmr == 3'h0) begin
          next_st = ST_IDLE;
        end else begin
          next_tmr = tmr - 3'h1;
        end
      end
      ST_RF: begin
        if (tmr == 3'h0) begin
          next_st = ST_RFPRE;
          next_ras = 2'b11;
          // Code 00..11 gives 1..4 clocks
          next_tmr = adr_pkg::RPC_BASE_CLKS
            + {1'b0, dram_config[adr_pkg::CFG_RPC_LSB +: 2]} - 3'h1;
        end else begin
          next_tmr = tmr - 3'h1;
        end
      end
      ST_RFPRE: begin
        if (tmr == 3'h0) begin
          next_st = ST_IDLE;
          next_busy = 1'b0;
        end else begin
          next_tmr = tmr - 3'h1;
        end
      end
      default: begin
        next_st = ST_IDLE;
        next_ras = 2'b11;
        next_cas = 4'hF;
      end
    endcase
  end
  // Sequencer registers
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st <= ST_IDLE;
      tmr <= 3'h0;
      blk <= 1'b0;
      ras_q <= 2'h3;
      cas_q <= 4'hF;
      mem_ack_out <= 1'b0;
      write_indicator_n_out <= 1'b1;
      refresh_busy_out <= 1'b0;
      dram_addr_out <= 32'h00000000;
      sync_mode_out <= 1'b0;
    end else begin
      st <= next_st;
      tmr <= next_tmr;
      blk <= next_blk;
      ras_q <= next_ras;
      cas_q <= next_cas;
      mem_ack_out <= next_mack;
      write_indicator_n_out <= next_wi_n;
      refresh_busy_out <= next_busy;
      dram_addr_out <= next_addr;
      sync_mode_out <= next_config[adr_pkg::CFG_SYNC_BIT];
    end
  end
  // Pin retiming to the falling edge
  adr_strobe_neg u_neg (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .ras_n_in(ras_q),
    .cas_n_in(cas_q),
    .ras_n_out(ras_n_out),
    .cas_n_out(cas_n_out)
  );
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_rf_start;
    st == ST_IDLE && next_st == ST_RF && dram_config[12:11] == 2'b00;
  endsequence
  sync_sticky_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    dram_config[15] |=> dram_config[15])
    else $error("sync mode cleared");
  rsvd_zero_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    dram_config[14] == 1'b0)
    else $error("reserved bit set");
  rf_width_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_rf_start |=> (st == ST_RF) [*2] ##1 st == ST_RFPRE)
    else $error("refresh strobe width wrong");
  write_ind_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (st == ST_COL) |-> (write_indicator_n_out == ~mem_wr_in))
    else $error("write indicator wrong");
  term_once_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (st == ST_COL && next_st == ST_PRE) |=> mem_ack_out ##1 !mem_ack_out)
    else $error("termination missing");
  // Enables may be cleared mid-refresh, so judge them at the start only
  rf_enable_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (st == ST_IDLE && rf_req) |=> (ras_q == ~$past(keep)))
    else $error("refresh on disabled block");
  ext_open_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (reg_sel_in && reg_ext_in) |=> reg_ack_out)
    else $error("off-chip register access refused");
  rf_first_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (st == ST_IDLE && rf_req) |=> st == ST_RF)
    else $error("access ahead of refresh");
  one_row_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (st == ST_ROW) |-> $onehot(~ras_q))
    else $error("row strobe not single");
endmodule

// ===== verif/adr_dram_model.sv
// Purpose: Behavioural DRAM pin monitor for the refresh controller bench
// Assumes: Active-low strobes; no data bus is modelled on this block
// Notes:   Latches strobe and address state while a column strobe is low
module adr_dram_model (
  input wire logic clk_in, // Bus clock
  input wire logic rst_in, // Reset, active high
  input wire logic [1:0] ras_n_in, // Row strobes from pins
  input wire logic [3:0] cas_n_in, // Column strobes from pins
  input wire logic [31:0] addr_in, // Address bus from pins
  output logic [1:0] ras_seen_out, // Row strobes at column time
  output logic [3:0] cas_seen_out, // Lanes at column time
  output logic [31:0] col_seen_out, // Column address latched
  output int edge_err_out // Strobe moves while clock high
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Strobe timing watch
  // ----------------------------------------------------------------
  initial edge_err_out = 0;
  // A strobe moving with the clock high missed the falling edge
  always @(ras_n_in or cas_n_in) begin
    if (rst_in === 1'b0 && clk_in === 1'b1) edge_err_out = edge_err_out + 1;
  end
  // ----------------------------------------------------------------
  // Column capture
  // ----------------------------------------------------------------
  // Sample just after the falling edge, once the pins have settled
  always @(negedge clk_in) begin
    #1;
    if (cas_n_in !== 4'hF) begin
      ras_seen_out = ras_n_in;
      cas_seen_out = cas_n_in;
      col_seen_out = addr_in;
    end
  end
endmodule

// ===== verif/adr_ctrl_tb_top.sv
// Purpose: Self-checking bench for the asynchronous DRAM refresh controller
// Assumes: Inputs change 1 ns after the rising edge; short refresh counts, one full 9'h1FF run
// Notes:   Sync mode is sticky, so its scenario runs last and ends in reset
module adr_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_sys_in, sys_rst_in, reg_sel_in, reg_wr_in, reg_ext_in, mem_req_in, mem_wr_in;
  logic [8:0] reg_addr_in; // Register offset
  logic [31:0] reg_wdata_in, reg_rdata_out, mem_addr_in, dram_addr_out, col_seen, rd;
  logic [3:0] mem_be_in, cas_n_out, cas_seen; // Lanes
  logic [1:0] ras_n_out, ras_seen; // Rows
  logic reg_ack_out, mem_ack_out, write_indicator_n_out, sync_mode_out, refresh_busy_out;
  int num_errors = 0; // Mismatches
  int tests_run = 0; // Comparisons
  int edge_err; // Strobe timing faults
  logic [8:0] offs [5] = '{9'h100, 9'h108, 9'h10C, 9'h110, 9'h114}; // Map
  // Patterns avoid reserved bits, which software keeps clear
  logic [31:0] vals [5] = '{32'h2E05_0000, 32'hABC0_3D00, 32'h5554_0000,
                            32'h8C40_2500, 32'h2AA8_0000};
  adr_ctrl uut (.clk_sys_in, .sys_rst_in, .reg_sel_in, .reg_wr_in, .reg_ext_in, .reg_addr_in,
    .reg_wdata_in, .reg_rdata_out, .reg_ack_out, .mem_req_in, .mem_wr_in, .mem_addr_in,
    .mem_be_in, .mem_ack_out, .dram_addr_out, .ras_n_out, .cas_n_out, .write_indicator_n_out,
    .sync_mode_out, .refresh_busy_out);
  adr_dram_model dram (.clk_in(clk_sys_in), .rst_in(sys_rst_in), .ras_n_in(ras_n_out),
    .cas_n_in(cas_n_out), .addr_in(dram_addr_out), .ras_seen_out(ras_seen),
    .cas_seen_out(cas_seen), .col_seen_out(col_seen), .edge_err_out(edge_err));
  // 100 MHz clock
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic results;
    $display("errors %0d in %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(posedge clk_sys_in);
    #1;
  endtask
  // One register cycle; off-chip flag varies with the offset
  task automatic reg_acc(input logic wr, input logic [8:0] a, input logic [31:0] d);
    int n;
    tick();
    reg_sel_in = 1'b1;
    reg_wr_in = wr;
    reg_ext_in = a[3];
    reg_addr_in = a;
    reg_wdata_in = d;
    tick();
    reg_sel_in = 1'b0;
    n = 0;
    while (reg_ack_out !== 1'b1 && n < 4) begin
      tick();
      n++;
    end
    if (n == 4) begin
      num_errors++;
      results();
    end
    rd = reg_rdata_out;
  endtask
  // Skip any refresh in progress, then wait for the next to start
  task automatic wrise(output int n);
    int w;
    w = 0;
    n = 0;
    while (refresh_busy_out === 1'b1 && w < 20) begin
      tick();
      w++;
    end
    while (refresh_busy_out !== 1'b1 && n < 9000) begin
      tick();
      n++;
    end
    if (n == 9000) begin
      num_errors++;
      results();
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_map;
    for (int k = 0; k < 5; k++) begin
      reg_acc(1'b0, offs[k], 32'h0);
      chk(rd, 32'h0);
    end
    for (int k = 0; k < 5; k++) reg_acc(1'b1, offs[k], vals[k]);
    reg_acc(1'b1, 9'h104, 32'hFFFF_FFFF);
    reg_acc(1'b0, 9'h104, 32'h0);
    chk(rd, 32'h0);
    for (int k = 0; k < 5; k++) begin
      reg_acc(1'b0, offs[k], 32'h0);
      chk(rd, vals[k]);
    end
  endtask
  // Every strobe width and precharge code, three refresh intervals
  task automatic t_refresh;
    int n, hi, r0, r1;
    logic [1:0] c;
    logic [8:0] cnt;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      cnt = (i == 3) ? 9'h1FF : {7'h0, c};
      reg_acc(1'b1, 9'h108, 32'h0000_8000);
      reg_acc(1'b1, 9'h110, {16'h8000, c[0], 15'h0});
      reg_acc(1'b1, 9'h100, {3'b000, c, c ^ 2'b01, cnt, 16'h0});
      // New count takes effect at a reload, so skip one interval
      wrise(n);
      wrise(n);
      hi = 0;
      r0 = 0;
      r1 = 0;
      while (refresh_busy_out === 1'b1 && hi < 20) begin
        if (ras_n_out[0] === 1'b0) r0++;
        if (ras_n_out[1] === 1'b0) r1++;
        tick();
        hi++;
      end
      wrise(n);
      chk(32'(hi + n), 32'((cnt + 1) * 16));
      chk(32'(r0), 32'(i + 2));
      chk(32'(r1), c[0] ? 32'(i + 2) : 32'h0);
      chk(32'(hi), 32'(i + 3 + (i ^ 1)));
    end
    reg_acc(1'b1, 9'h108, 32'h0);
    reg_acc(1'b1, 9'h110, 32'h0);
  endtask
  task automatic access(input logic wr, input logic [31:0] a, input logic [3:0] be,
                        input logic nm, input int lat);
    int n;
    reg_acc(1'b1, 9'h100, {2'b00, nm, 29'h0});
    mem_req_in = 1'b1;
    mem_wr_in = wr;
    mem_addr_in = a;
    mem_be_in = be;
    n = 0;
    while (mem_ack_out !== 1'b1 && n < 40) begin
      tick();
      n++;
      if (n == 1) chk(dram_addr_out, a);
      if (mem_ack_out !== 1'b1) chk({31'h0, write_indicator_n_out}, {31'h0, !wr});
    end
    mem_req_in = 1'b0;
    chk(32'(n), 32'(lat));
    chk({30'h0, ras_seen}, a[31] ? 32'h1 : 32'h2);
    chk({28'h0, cas_seen}, {28'h0, ~{be[0], be[1], be[2], be[3]}});
    chk(col_seen, nm ? a : {16'h0, a[31:16]});
  endtask
  // Blocks split on address bit 31 so they never overlap
  task automatic t_access;
    reg_acc(1'b1, 9'h108, 32'h0000_2100);
    reg_acc(1'b1, 9'h10C, 32'h7FFC_0000);
    reg_acc(1'b1, 9'h110, 32'h8000_0000);
    reg_acc(1'b1, 9'h114, 32'h7FFC_0000);
    access(1'b1, 32'h1234_5678, 4'b1000, 1'b0, 6);
    access(1'b0, 32'h8765_4320, 4'b0011, 1'b1, 3);
  endtask
  // Access requested mid-refresh must wait for refresh and precharge
  task automatic t_pending;
    int n, bad;
    reg_acc(1'b1, 9'h108, 32'h0000_A100);
    reg_acc(1'b1, 9'h100, 32'h1E00_0000);
    wrise(n);
    mem_req_in = 1'b1;
    mem_wr_in = 1'b0;
    mem_addr_in = 32'h0000_0100;
    mem_be_in = 4'hF;
    n = 0;
    bad = 0;
    while (mem_ack_out !== 1'b1 && n < 40) begin
      tick();
      n++;
      if (refresh_busy_out === 1'b1 && (cas_n_out !== 4'hF || mem_ack_out === 1'b1)) bad++;
    end
    mem_req_in = 1'b0;
    chk(32'(bad), 32'h0);
    chk(32'(n > 8), 32'h1);
    reg_acc(1'b1, 9'h108, 32'h0);
  endtask
  task automatic t_sync;
    int n;
    reg_acc(1'b1, 9'h108, 32'h0000_2100);
    reg_acc(1'b1, 9'h100, 32'h8000_0000);
    tick();
    chk({31'h0, sync_mode_out}, 32'h1);
    reg_acc(1'b1, 9'h100, 32'h0);
    reg_acc(1'b0, 9'h100, 32'h0);
    chk(rd, 32'h8000_0000);
    mem_req_in = 1'b1;
    mem_wr_in = 1'b1;
    mem_addr_in = 32'h0000_0040;
    n = 0;
    repeat (20) begin
      tick();
      if (mem_ack_out === 1'b1) n++;
    end
    mem_req_in = 1'b0;
    chk(32'(n), 32'h0);
    sys_rst_in = 1'b1;
    tick();
    tick();
    sys_rst_in = 1'b0;
    chk({31'h0, sync_mode_out}, 32'h0);
    reg_acc(1'b0, 9'h100, 32'h0);
    chk(rd, 32'h0);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst_in = 1'b1;
    {reg_sel_in, reg_wr_in, reg_ext_in, mem_req_in, mem_wr_in} = 5'h0;
    reg_addr_in = 9'h0;
    reg_wdata_in = 32'h0;
    mem_addr_in = 32'h0;
    mem_be_in = 4'h0;
    repeat (2) @(posedge clk_sys_in);
    #1;
    sys_rst_in = 1'b0;
    t_map();
    t_refresh();
    t_access();
    t_pending();
    t_sync();
    chk(32'(edge_err), 32'h0);
    results();
  end
endmodule
